//--- tsec_cfg.svh
// Constants for the two-stage event controller: offsets, levels, resets
`ifndef TSEC_CFG_SVH
`define TSEC_CFG_SVH

// Register byte offsets on the Wishbone slave
`define TSEC_OFS_LATCH 8'h00
`define TSEC_OFS_MASK 8'h04
`define TSEC_OFS_ACTIVE 8'h08
`define TSEC_OFS_PMASK 8'h0c
`define TSEC_OFS_PSTATUS 8'h10
`define TSEC_OFS_ASSIGN0 8'h14
`define TSEC_OFS_ASSIGN1 8'h18
`define TSEC_OFS_ASSIGN2 8'h1c
`define TSEC_OFS_CTRL 8'h20

// Event levels, 0 highest
`define TSEC_LVL_EMU 4'h0
`define TSEC_LVL_RST 4'h1
`define TSEC_LVL_NMI 4'h2
`define TSEC_LVL_EXC 4'h3
`define TSEC_LVL_RSVD 4'h4
`define TSEC_LVL_HWERR 4'h5
`define TSEC_LVL_TIMER 4'h6
`define TSEC_LVL_GP_FIRST 4'h7

// Field positions
`define TSEC_CTRL_GEN_BIT 0
`define TSEC_ASSIGN_FIELD_W 4

// Levels 0..3 can never be masked
`define TSEC_NOMASK_BITS 16'h000f
// Level 4 is reserved and never latches
`define TSEC_RSVD_BITS 16'h0010

// Reset values
`define TSEC_RST_MASK 16'h0000
`define TSEC_RST_PMASK 32'h0000_0000
`define TSEC_RST_ASSIGN0 32'h1000_0000
`define TSEC_RST_ASSIGN1 32'h3332_2221
`define TSEC_RST_ASSIGN2 32'h6665_5444
`define TSEC_RST_CTRL 32'h0000_0001

`endif

//--- tsec_pkg.sv
// Types shared by the two-stage event controller modules
package tsec_pkg;

  // Winner of a priority search
  typedef struct packed {
    logic valid;
    logic [3:0] level;
  } event_pick_type;

  // One Wishbone request as seen by the slave
  typedef struct packed {
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
    logic supervisor;
  } bus_req_type;

endpackage

//--- event_priority_select.sv
// Lowest-index (highest-priority) set bit finder
`timescale 1ns/1ps
module event_priority_select #(
  parameter int N = 16
) (
  // Request bits, bit 0 highest priority
  input wire logic [N-1:0] i_req,
  // Winner
  output tsec_pkg::event_pick_type o_pick
);

  // Scan from lowest priority up so the highest-priority set bit is kept last
  function automatic tsec_pkg::event_pick_type pick_first(input logic [N-1:0] req);
    tsec_pkg::event_pick_type p;
    p = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        p.valid = 1'b1;
        p.level = 4'(i);
      end
    end
    return p;
  endfunction

  assign o_pick = pick_first(i_req);

endmodule

//--- system_interrupt_stage.sv
// Peripheral source masking, status and routing onto general levels
`timescale 1ns/1ps
`include "tsec_cfg.svh"
module system_interrupt_stage #(
  parameter int NUM_SRC = 24,
  parameter int NUM_LVL = 9
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Peripheral requests, same clock domain
  input wire logic [NUM_SRC-1:0] i_src,
  // Configuration from the register file
  input wire logic [NUM_SRC-1:0] i_mask,
  input wire logic [NUM_SRC*`TSEC_ASSIGN_FIELD_W-1:0] i_assign,
  // Routed general levels and source status
  output logic [NUM_LVL-1:0] o_level,
  output logic [NUM_SRC-1:0] o_status
);

  logic [NUM_LVL-1:0] next_level;

  // Each level ORs the unmasked sources whose field selects it
  genvar g;
  generate
    for (g = 0; g < NUM_LVL; g++) begin : g_lvl
      logic [NUM_SRC-1:0] hit;
      for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
        assign hit[s] = i_src[s] & i_mask[s] &
          (i_assign[s*`TSEC_ASSIGN_FIELD_W +: `TSEC_ASSIGN_FIELD_W] == 4'(g));
      end
      assign next_level[g] = |hit;
    end
  endgenerate

  // Status shows raw assertion so software can find a shared source
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_level <= '0;
      o_status <= '0;
    end else begin
      o_level <= next_level;
      o_status <= i_src;
    end
  end

endmodule

//--- two_stage_event_controller.sv
// Two-stage event controller: core event stage with Wishbone registers
`timescale 1ns/1ps
`include "tsec_cfg.svh"
module two_stage_event_controller #(
  parameter int NUM_SRC = 24,
  parameter int NUM_LVL = 9,
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic i_wb_supervisor,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Event pins from outside the chip
  input wire logic i_emu_pin,
  input wire logic i_nmi_pin,
  // Core-side event sources
  input wire logic i_reset_event,
  input wire logic i_watchdog_nmi,
  input wire logic i_misaligned,
  input wire logic i_undefined_insn,
  input wire logic i_hw_error,
  input wire logic i_core_timer,
  input wire logic [NUM_SRC-1:0] i_periph_irq,
  // Software interrupt instruction
  input wire logic i_sw_raise,
  input wire logic [3:0] i_sw_level,
  // Pipeline event hand-off
  output logic o_event_valid,
  output logic [3:0] o_event_level,
  input wire logic i_event_accept,
  input wire logic [ADDR_W-1:0] i_resume_addr,
  output logic o_save_state,
  output logic o_core_reset,
  output logic o_emu_mode,
  output logic o_hold_commit,
  // Return from event
  input wire logic i_return,
  input wire logic [3:0] i_return_level,
  output logic [ADDR_W-1:0] o_return_addr,
  // Active bits, as read at TSEC_OFS_ACTIVE
  output logic [15:0] o_event_active
);

  // Register state
  logic [15:0] event_latch_bits;
  logic [15:0] core_event_mask;
  logic [15:0] event_active_bits;
  logic [NUM_SRC-1:0] peripheral_event_mask;
  logic [31:0] source_assignment_regs [3];
  logic [31:0] ctrl;
  logic [NUM_SRC-1:0] peripheral_event_status;
  logic [ADDR_W-1:0] return_addr_regs [16];

  // Bus decode
  tsec_pkg::bus_req_type req;
  logic bus_hit;
  logic bus_wr;
  logic bus_rd_ok;
  logic [31:0] rd_mux;
  logic [31:0] next_rd;

  assign req.we = i_wb_we;
  assign req.sel = i_wb_sel;
  assign req.adr = i_wb_adr;
  assign req.dat = i_wb_dat;
  assign req.supervisor = i_wb_supervisor;

  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input tsec_pkg::bus_req_type r);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (r.sel[b]) begin
        v[b*8 +: 8] = r.dat[b*8 +: 8];
      end
    end
    return v;
  endfunction

  // Register hit decode for writes; the read mux decodes req.adr in its own case statement
  function automatic logic at(input tsec_pkg::bus_req_type r, input logic [7:0] ofs);
    return r.adr == ofs;
  endfunction

  // A new request each cycle the strobe stands and no ack is out
  assign bus_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign bus_wr = bus_hit & req.we & req.supervisor;
  assign bus_rd_ok = req.supervisor;

  // Pin synchronisers, first stage read only by the second
  logic emu_s1;
  logic emu_s2;
  logic nmi_s1;
  logic nmi_s2;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      emu_s1 <= 1'b0;
      emu_s2 <= 1'b0;
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
    end else begin
      emu_s1 <= i_emu_pin;
      emu_s2 <= emu_s1;
      nmi_s1 <= i_nmi_pin;
      nmi_s2 <= nmi_s1;
    end
  end

  // System stage: peripheral routing onto the general levels
  logic [NUM_LVL-1:0] gp_level;
  logic [95:0] assign_flat;

  // Assignment words packed so each source sees its own 4-bit field
  assign assign_flat = {source_assignment_regs[2], source_assignment_regs[1],
                        source_assignment_regs[0]};

  system_interrupt_stage #(
    .NUM_SRC(NUM_SRC),
    .NUM_LVL(NUM_LVL)
  ) u_sis (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_src(i_periph_irq),
    .i_mask(peripheral_event_mask),
    .i_assign(assign_flat[NUM_SRC*`TSEC_ASSIGN_FIELD_W-1:0]),
    .o_level(gp_level),
    .o_status(peripheral_event_status)
  );

  // Raw event levels by priority position
  logic [15:0] ev_raw;
  logic [15:0] ev_d1;
  logic [15:0] ev_d2;
  logic [15:0] ev_rise;

  // nine general inputs on bits 7..15
  // fixed level order, level 4 tied off
  assign ev_raw = {gp_level, i_core_timer, i_hw_error, 1'b0,
                   i_misaligned | i_undefined_insn, nmi_s2 | i_watchdog_nmi,
                   i_reset_event, emu_s2};

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ev_d1 <= '0;
      ev_d2 <= '0;
    end else begin
      ev_d1 <= ev_raw;
      ev_d2 <= ev_d1;
    end
  end

  assign ev_rise = ev_d1 & ~ev_d2;

  // Software interrupt instruction raises one level directly
  logic [15:0] sw_set;
  assign sw_set = i_sw_raise ? (16'h0001 << i_sw_level) : 16'h0000;

  // Grant bookkeeping
  tsec_pkg::event_pick_type grant;
  tsec_pkg::event_pick_type next_grant;
  tsec_pkg::event_pick_type act_pick;
  tsec_pkg::event_pick_type cand_pick;
  logic take;
  logic [15:0] take_bit;
  logic [15:0] ret_bit;

  assign take = o_event_valid & i_event_accept;
  assign take_bit = take ? (16'h0001 << grant.level) : 16'h0000;
  assign ret_bit = i_return ? (16'h0001 << i_return_level) : 16'h0000;

  // Latch: write only where masked, clear on entry, new edges win
  logic [15:0] latch_wr;
  logic [15:0] next_latch;
  logic [31:0] latch_merged;
  logic [31:0] mask_merged;
  logic [31:0] pmask_merged;

  // Merged write values, sliced to the register widths on purpose
  assign latch_merged = merge({16'h0000, event_latch_bits}, req);
  assign mask_merged = merge({16'h0000, core_event_mask}, req);
  assign pmask_merged = merge(32'(peripheral_event_mask), req);
  assign latch_wr = latch_merged[15:0];
  always_comb begin
    next_latch = event_latch_bits;
    if (bus_wr && at(req, `TSEC_OFS_LATCH)) begin
      next_latch = (event_latch_bits & core_event_mask) | (latch_wr & ~core_event_mask);
    end
    next_latch = next_latch & ~take_bit;
    next_latch = (next_latch | ev_rise | sw_set) & ~`TSEC_RSVD_BITS;
  end

  logic [15:0] next_active;
  assign next_active = (event_active_bits & ~ret_bit) | take_bit;

  // Eligible events: latched, unmasked, globally enabled for general levels
  logic [15:0] eff_mask;
  logic [15:0] above_active;
  logic [15:0] cand;

  assign eff_mask = (core_event_mask | `TSEC_NOMASK_BITS) &
                    {{NUM_LVL{ctrl[`TSEC_CTRL_GEN_BIT]}}, 7'h7f};

  event_priority_select #(.N(16)) u_act_sel (
    .i_req(event_active_bits),
    .o_pick(act_pick)
  );

  // only levels above the best active one may preempt
  genvar k;
  generate
    for (k = 0; k < 16; k++) begin : g_above
      assign above_active[k] = ~act_pick.valid | (4'(k) < act_pick.level);
    end
  endgenerate

  assign cand = event_latch_bits & eff_mask & above_active;

  event_priority_select #(.N(16)) u_cand_sel (
    .i_req(cand),
    .o_pick(cand_pick)
  );

  // A grant is withdrawn the cycle after it is taken to avoid a double entry
  assign next_grant = take ? '0 : cand_pick;

  // Grant register and latch/active state
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      grant <= '0;
      event_latch_bits <= '0;
      event_active_bits <= '0;
    end else begin
      grant <= next_grant;
      event_latch_bits <= next_latch;
      event_active_bits <= next_active;
    end
  end

  // active bit earliest four clocks after a core source edge, six after a pin edge
  assign o_event_valid = grant.valid & event_latch_bits[grant.level];
  assign o_event_level = grant.level;
  assign o_event_active = event_active_bits;

  always_ff @(posedge i_core_clk) begin
    if (take) begin
      return_addr_regs[grant.level] <= i_resume_addr;
    end
  end

  // Entry and return side effects, registered pulses and levels
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_save_state <= 1'b0;
      o_core_reset <= 1'b0;
      o_return_addr <= '0;
    end else begin
      o_save_state <= take;
      o_core_reset <= take & (grant.level == `TSEC_LVL_RST);
      if (i_return) begin
        o_return_addr <= return_addr_regs[i_return_level];
      end
    end
  end

  // emulation mode while level 0 is active
  assign o_emu_mode = event_active_bits[`TSEC_LVL_EMU];

  // hold commit while an exception is raised or pending
  assign o_hold_commit = i_misaligned | i_undefined_insn |
                         event_latch_bits[`TSEC_LVL_EXC];

  // Configuration registers written by software
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      core_event_mask <= `TSEC_RST_MASK;
      peripheral_event_mask <= NUM_SRC'(`TSEC_RST_PMASK);
      source_assignment_regs[0] <= `TSEC_RST_ASSIGN0;
      source_assignment_regs[1] <= `TSEC_RST_ASSIGN1;
      source_assignment_regs[2] <= `TSEC_RST_ASSIGN2;
      ctrl <= `TSEC_RST_CTRL;
    end else if (bus_wr) begin
      if (at(req, `TSEC_OFS_MASK)) begin
        core_event_mask <= mask_merged[15:0];
      end
      if (at(req, `TSEC_OFS_PMASK)) begin
        peripheral_event_mask <= pmask_merged[NUM_SRC-1:0];
      end
      if (at(req, `TSEC_OFS_ASSIGN0)) begin
        source_assignment_regs[0] <= merge(source_assignment_regs[0], req);
      end
      if (at(req, `TSEC_OFS_ASSIGN1)) begin
        source_assignment_regs[1] <= merge(source_assignment_regs[1], req);
      end
      if (at(req, `TSEC_OFS_ASSIGN2)) begin
        source_assignment_regs[2] <= merge(source_assignment_regs[2], req);
      end
      if (at(req, `TSEC_OFS_CTRL)) begin
        ctrl <= merge(ctrl, req) & 32'h0000_0001;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (req.adr)
      `TSEC_OFS_LATCH: rd_mux = {16'h0000, event_latch_bits};
      `TSEC_OFS_MASK: rd_mux = {16'h0000, core_event_mask};
      `TSEC_OFS_ACTIVE: rd_mux = {16'h0000, event_active_bits};
      `TSEC_OFS_PMASK: rd_mux = 32'(peripheral_event_mask);
      `TSEC_OFS_PSTATUS: rd_mux = 32'(peripheral_event_status);
      `TSEC_OFS_ASSIGN0: rd_mux = source_assignment_regs[0];
      `TSEC_OFS_ASSIGN1: rd_mux = source_assignment_regs[1];
      `TSEC_OFS_ASSIGN2: rd_mux = source_assignment_regs[2];
      `TSEC_OFS_CTRL: rd_mux = ctrl;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign next_rd = (bus_hit & ~req.we & bus_rd_ok) ? rd_mux : 32'h0000_0000;

  // One-cycle registered ack for every request, mapped or not
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= bus_hit;
      o_wb_dat <= next_rd;
    end
  end

endmodule

//--- tsec_props.sv
// Port-level checks for the two-stage event controller
`timescale 1ns/1ps
module tsec_props (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_supervisor,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Event sources and hand-off
  input wire logic i_misaligned,
  input wire logic i_undefined_insn,
  input wire logic o_event_valid,
  input wire logic [3:0] o_event_level,
  input wire logic i_event_accept,
  input wire logic o_save_state,
  input wire logic o_core_reset,
  input wire logic o_emu_mode,
  input wire logic o_hold_commit,
  input wire logic i_return,
  input wire logic [3:0] i_return_level,
  input wire logic [15:0] o_event_active
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // Bus answer is one pulse, one cycle after the strobe is taken
  a_ack_one_pulse: assert property (
    (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus ack not a single pulse");
  a_user_read_zero: assert property (
    (i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_supervisor) |=> o_wb_dat == 32'h0)
    else $error("user access returned data");
  a_save_on_take: assert property (
    (o_event_valid && i_event_accept) |=> o_save_state && !o_event_valid)
    else $error("state save or grant withdrawal missing");
  a_save_has_cause: assert property (
    o_save_state |-> $past(o_event_valid && i_event_accept))
    else $error("state save without accepted grant");
  a_reset_level_one: assert property (
    (o_event_valid && i_event_accept && o_event_level == 4'h1) |=> o_core_reset)
    else $error("reset event did not reset core");
  a_emu_mode_tracks: assert property (
    o_emu_mode == o_event_active[0])
    else $error("emulation mode differs from level zero");
  a_fault_holds: assert property (
    (i_misaligned || i_undefined_insn) |-> o_hold_commit)
    else $error("faulting instruction allowed to commit");
  a_grant_above_active: assert property (
    (o_event_valid && $past(o_event_valid))
    |-> (o_event_active & ((16'h2 << o_event_level) - 16'h1)) == 16'h0)
    else $error("grant not above every active level");
  a_active_on_take: assert property (
    (o_event_valid && i_event_accept) |=> o_event_active[$past(o_event_level)])
    else $error("active bit not set on take");
  a_return_clears: assert property (
    i_return |=> !o_event_active[$past(i_return_level)])
    else $error("return left level active");
  a_reserved_idle: assert property (
    !o_event_active[4])
    else $error("reserved level became active");
endmodule

//--- pipe_model.sv
// Pipeline stand-in: takes event grants and supplies resume addresses
`timescale 1ns/1ps
module pipe_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Grant from the controller
  input wire logic i_event_valid,
  input wire logic [3:0] i_event_level,
  // Bench control: stall, accept delay
  input wire logic i_stall,
  input wire logic [3:0] i_wait,
  // Accept and resume address
  output logic o_event_accept,
  output logic [31:0] o_resume_addr,
  // Last level taken, number of takes
  output logic [3:0] o_taken,
  output logic [7:0] o_takes
);
  logic [3:0] wait_cnt;

  // Accept after i_wait+1 cycles of grant; address scrambles when idle
  // one resume address per level
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_event_accept <= 1'b0;
      o_resume_addr <= 32'h0;
      o_taken <= 4'h0;
      o_takes <= 8'h0;
      wait_cnt <= 4'h0;
    end else begin
      o_event_accept <= 1'b0;
      o_resume_addr <= ~o_resume_addr;
      if (o_event_accept && i_event_valid) begin
        o_taken <= i_event_level;
        o_takes <= o_takes + 8'h1;
      end
      if (!o_event_accept && i_event_valid && !i_stall) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt >= i_wait) begin
          o_event_accept <= 1'b1;
          o_resume_addr <= 32'hc000_0000 | {28'h0, i_event_level};
        end
      end else begin
        wait_cnt <= 4'h0;
      end
    end
  end
endmodule

//--- tb_two_stage_event_controller.sv
// Self-checking bench for the two-stage event controller
`timescale 1ns/1ps
`include "tsec_cfg.svh"
module tb_two_stage_event_controller;
  logic i_core_clk, i_rst, cyc, stb, we, sup, o_wb_ack, sw_raise, ret, accept, stall;
  logic valid, save, core_rst, emulation_event_entry, hold;
  logic [7:0] adr, ev, takes, seen;
  logic [31:0] wdat, o_wb_dat, rd, ret_addr, resume;
  logic [23:0] irq;
  logic [3:0] sw_lvl, ret_lvl, lvl, taken, wait_n;
  logic [15:0] active;
  int fail_count, samples_checked;

  two_stage_event_controller DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
    .i_wb_supervisor(sup), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_emu_pin(ev[7]),
    .i_nmi_pin(ev[6]), .i_reset_event(ev[5]), .i_watchdog_nmi(ev[4]), .i_misaligned(ev[3]),
    .i_undefined_insn(ev[2]), .i_hw_error(ev[1]), .i_core_timer(ev[0]), .i_periph_irq(irq),
    .i_sw_raise(sw_raise), .i_sw_level(sw_lvl), .o_event_valid(valid), .o_event_level(lvl),
    .i_event_accept(accept), .i_resume_addr(resume), .o_save_state(save),
    .o_core_reset(core_rst), .o_emu_mode(emulation_event_entry), .o_hold_commit(hold), .i_return(ret),
    .i_return_level(ret_lvl), .o_return_addr(ret_addr), .o_event_active(active));

  pipe_model u_pipe (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_event_valid(valid),
    .i_event_level(lvl), .i_stall(stall), .i_wait(wait_n), .o_event_accept(accept),
    .o_resume_addr(resume), .o_taken(taken), .o_takes(takes));

  // Free-running core clock, 40 ns
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic single Wishbone cycle; the bench never assumes the answer delay
  task automatic wb(input logic w, input logic s, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sup <= s;
    adr <= a;
    wdat <= d;
    #1;
    // Ack is read settled, so it is the value the next edge samples
    for (k = 0; k < 20 && o_wb_ack !== 1'b1; k++) begin
      @(posedge i_core_clk);
      #1;
    end
    if (k == 20) begin
      fail_count++;
      summarize();
    end
    rd = o_wb_dat;
    @(posedge i_core_clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, 1'b1, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // Wait for the pipeline model to take the next grant
  task automatic wait_take(input logic [3:0] e);
    int k;
    for (k = 0; k < 60 && takes === seen; k++) begin
      @(posedge i_core_clk);
      #1;
    end
    if (k == 60) begin
      fail_count++;
      summarize();
    end
    seen = takes;
    chk("taken level", {28'h0, taken}, {28'h0, e});
  endtask

  task automatic ret_ev(input logic [3:0] l);
    @(posedge i_core_clk);
    ret <= 1'b1;
    ret_lvl <= l;
    @(posedge i_core_clk);
    ret <= 1'b0;
    #1;
    chk("return addr", ret_addr, 32'hc000_0000 | {28'h0, l});
    chk("active cleared", {31'h0, active[l]}, 32'h0);
  endtask

  initial begin
    int i;
    logic [3:0] e;
    {cyc, stb, we, sup, sw_raise, ret, stall} = '0;
    {adr, ev, wdat, irq, sw_lvl, ret_lvl, wait_n} = '0;
    fail_count = 0;
    samples_checked = 0;
    i_rst = 1'b1;
    repeat (5) @(posedge i_core_clk);
    i_rst <= 1'b0;
    seen = 8'h0;
    // Reset mapping and masks
    rchk("mask", `TSEC_OFS_MASK, {16'h0, `TSEC_RST_MASK});
    rchk("pmask", `TSEC_OFS_PMASK, `TSEC_RST_PMASK);
    rchk("assign0", `TSEC_OFS_ASSIGN0, `TSEC_RST_ASSIGN0);
    rchk("assign1", `TSEC_OFS_ASSIGN1, `TSEC_RST_ASSIGN1);
    rchk("assign2", `TSEC_OFS_ASSIGN2, `TSEC_RST_ASSIGN2);
    rchk("ctrl", `TSEC_OFS_CTRL, `TSEC_RST_CTRL);
    // User mode sees reserved space; unmapped offset reads zero
    wb(1'b1, 1'b0, `TSEC_OFS_MASK, 32'hffff);
    rchk("mask after user write", `TSEC_OFS_MASK, 32'h0);
    wb(1'b0, 1'b0, `TSEC_OFS_CTRL, 32'h0);
    chk("user read", rd, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    // Masked hardware error stays latched, unserviced
    ev[1] <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    chk("masked takes", {24'h0, takes}, 32'h0);
    rchk("latch held", `TSEC_OFS_LATCH, 32'h20);
    wb(1'b1, 1'b1, `TSEC_OFS_MASK, 32'hffff);
    wait_take(4'h5);
    rchk("latch cleared", `TSEC_OFS_LATCH, 32'h0);
    rchk("active", `TSEC_OFS_ACTIVE, 32'h20);
    ev[1] <= 1'b0;
    ret_ev(4'h5);
    // Every dedicated source, with its fixed level
    for (i = 0; i < 8; i++) begin
      e = 4'(32'h0212_3356 >> (i * 4));
      @(posedge i_core_clk);
      ev[i] <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      #1;
      chk("early active", {31'h0, active[e]}, 32'h0);
      if (i == 2 || i == 3)
        chk("commit held", {31'h0, hold}, 32'h1);
      wait_take(e);
      chk("state saved", {31'h0, save}, 32'h1);
      chk("core reset", {31'h0, core_rst}, {31'h0, i == 5});
      #1;
      chk("emu mode", {31'h0, emulation_event_entry}, {31'h0, i == 7});
      ev[i] <= 1'b0;
      ret_ev(e);
    end
    // Stalled pipeline, three pending levels, slow accept
    wb(1'b1, 1'b1, `TSEC_OFS_PMASK, 32'h1);
    stall <= 1'b1;
    wait_n <= 4'h5;
    ev[1:0] <= 2'b11;
    irq[0] <= 1'b1;
    repeat (10) @(posedge i_core_clk);
    rchk("status", `TSEC_OFS_PSTATUS, 32'h1);
    ev[1:0] <= 2'b00;
    irq[0] <= 1'b0;
    stall <= 1'b0;
    wait_take(4'h5);
    ret_ev(4'h5);
    wait_take(4'h6);
    ret_ev(4'h6);
    wait_take(4'h7);
    ret_ev(4'h7);
    wait_n <= 4'h0;
    // Remapped source nested under a hardware error
    wb(1'b1, 1'b1, `TSEC_OFS_ASSIGN0, 32'h1000_0003);
    irq[0] <= 1'b1;
    wait_take(4'ha);
    irq[0] <= 1'b0;
    ev[1] <= 1'b1;
    wait_take(4'h5);
    chk("nested", {16'h0, active}, 32'h0420);
    ev[1] <= 1'b0;
    ret_ev(4'h5);
    ret_ev(4'ha);
    // software handlers kept on the two lowest levels
    for (i = 14; i < 16; i++) begin
      @(posedge i_core_clk);
      sw_raise <= 1'b1;
      sw_lvl <= 4'(i);
      @(posedge i_core_clk);
      sw_raise <= 1'b0;
      wait_take(4'(i));
      ret_ev(4'(i));
    end
    summarize();
  end
endmodule

bind two_stage_event_controller tsec_props u_props (.i_core_clk, .i_rst, .i_wb_cyc,
  .i_wb_stb, .i_wb_supervisor, .o_wb_dat, .o_wb_ack, .i_misaligned, .i_undefined_insn,
  .o_event_valid, .o_event_level, .i_event_accept, .o_save_state, .o_core_reset,
  .o_emu_mode, .o_hold_commit, .i_return, .i_return_level, .o_event_active);
